//--- logic/voltage_memory_map.vh
// Constants for the voltage angle memory block: modes, timing counts, event codes.
// Assumes a 250 MHz sys_clk; included by bare name from every file that uses its constants.
`ifndef VOLTAGE_MEMORY_MAP_VH
`define VOLTAGE_MEMORY_MAP_VH
// ****************************************************************
// Voltage measurement modes
// ****************************************************************
`define MODE_THREE_PHASE_NEUTRAL 2'h0
`define MODE_THREE_LINE_LINE 2'h1
`define MODE_TWO_LINE_LINE 2'h2
`define MODE_TWO_LINE_PLUS_RESIDUAL 2'h3
// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ 250
`define RMS_TICK_MS 5
`define RMS_TICK_CYCLES (`RMS_TICK_MS * 1000 * `CLK_MHZ)
`define HOLD_STEP_MS 10
`define HOLD_STEP_CYCLES (`HOLD_STEP_MS * 1000 * `CLK_MHZ)
`define HOLD_MIN_STEPS 16'h0002
`define HOLD_MAX_STEPS 16'h1388
`define ENGAGE_MIN_V 16'h00C8
`define ENGAGE_MAX_V 16'h1388
// ****************************************************************
// Event codes
// ****************************************************************
`define EV_ENABLED 4'h0
`define EV_DISABLED 4'h1
`define EV_VLOW_ON 4'h2
`define EV_VLOW_OFF 4'h3
`define EV_IHIGH_ON 4'h4
`define EV_IHIGH_OFF 4'h5
`define EV_FTRACK_ON 4'h6
`define EV_FTRACK_OFF 4'h7
`define EV_INUSE_ON 4'h8
`define EV_INUSE_OFF 4'h9
`define EV_BLOCK_ON 4'hA
`define EV_BLOCK_OFF 4'hB
`define EV_COUNT 12
`endif

//--- logic/pulse_divider.v
// Divider that emits a one-cycle enable every LIMIT cycles.
// Assumes one clock, sys_clk; synchronous active-low reset.
`timescale 1ns/1ns
module pulse_divider
#(
   parameter [31:0] LIMIT = 32'h0000_0002
)
(
   input wire sys_clk,
   input wire resetn,
   input wire run,
   output reg tick_ff
);
   reg [31:0] count_ff;
   wire [31:0] nxt_count;

   // Wrap counter, restarts while run is low
   assign nxt_count = (count_ff == LIMIT - 32'h0000_0001) ? 32'h0000_0000 : count_ff + 32'h0000_0001;

   // Counter and tick register
   always @(posedge sys_clk)
   begin
      if (!resetn || !run)
      begin
         count_ff <= 32'h0000_0000;
         tick_ff <= 1'b0;
      end
      else
      begin
         count_ff <= nxt_count;
         tick_ff <= (count_ff == LIMIT - 32'h0000_0001);
      end
   end
endmodule

//--- logic/event_encoder.v
// Turns per-event strobes into one coded event pulse, lowest code first.
// Assumes strobes are held pending until sent; one event leaves per cycle.
`timescale 1ns/1ns
`include "voltage_memory_map.vh"
module event_encoder
(
   input wire sys_clk,
   input wire resetn,
   input wire [`EV_COUNT-1:0] evStrobe,
   input wire [`EV_COUNT-1:0] evStoreMask,
   output reg evValid_ff,
   output reg [3:0] evCode_ff
);
   reg [`EV_COUNT-1:0] pend_ff;
   reg [`EV_COUNT-1:0] nxt_pend;
   reg [`EV_COUNT-1:0] pick;
   reg [3:0] pickCode;
   reg found;
   integer i;

   // Pick lowest pending event; new strobes join the pending set
   always @*
   begin
      pick = {`EV_COUNT{1'b0}};
      pickCode = 4'h0;
      found = 1'b0;
      for (i = 0; i < `EV_COUNT; i = i + 1)
      begin
         if (pend_ff[i] && !found)
         begin
            found = 1'b1;
            pick[i] = 1'b1;
            pickCode = i[3:0];
         end
      end
      nxt_pend = (pend_ff & ~pick) | (evStrobe & evStoreMask);
   end

   // Pending set and output event
   always @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         pend_ff <= {`EV_COUNT{1'b0}};
         evValid_ff <= 1'b0;
         evCode_ff <= 4'h0;
      end
      else
      begin
         pend_ff <= nxt_pend;
         evValid_ff <= found;
         evCode_ff <= pickCode;
      end
   end
endmodule

//--- logic/voltage_angle_memory.v
// Voltage angle memory: holds amplitude and pre-fault angles while voltages collapse.
// Assumes RMS and angle inputs synchronous to sys_clk, refreshed every 5 ms.
// Operation
// - Enable setting; disabled means the memory never engages.
// - Engage only when every used voltage is below the engage threshold.
// - With current qualification on, one phase current must also exceed threshold.
// - While engaged, report the engage threshold as voltage amplitude.
// - While engaged, supply angles latched just before the fault.
// - Memory-in-use flag output while engaged.
// - Blocking input sampled once at the start of each program cycle.
// - Inputs are RMS currents and four voltages on a 5 ms base.
// - Three channels in three-channel modes, two in two line-line mode.
// - Two line-line plus residual mode uses calculated phase-neutral voltages.
// - Engagement limited by definite hold limit, 0.02 to 50 s.
// - After hold expiry, signal stages to fall back to unidirectional.
// - Typical hold is 0.5 to 1.0 s; longer only with backup.
// - Fixed sampling mode uses the configured fixed frequency.
// - In fixed sampling mode, forced current following uses phase C frequency when voltages are absent.
// - Events: enabled/disabled and ON/OFF pairs for five conditions.
// - User chooses for all events together whether ON, OFF or both are stored.
`timescale 1ns/1ns
`include "voltage_memory_map.vh"
module voltage_angle_memory
#(
   // Program cycle and hold step lengths in clock cycles, 5 ms and 10 ms by default
   parameter [31:0] CYCLE_TICKS = `RMS_TICK_CYCLES,
   parameter [31:0] HOLD_TICKS = `HOLD_STEP_CYCLES
)
(
   input wire sys_clk,
   input wire resetn,
   input wire memoryEnable,
   input wire currentQualifyEnable,
   input wire currentBasedFreqFollow,
   input wire fixedSamplingMode,
   input wire [1:0] voltageMode,
   input wire [15:0] memoryEngageThreshold,
   input wire [15:0] currentQualifyThreshold,
   input wire [15:0] memoryHoldLimit,
   input wire memoryBlock,
   input wire [15:0] fixedFrequency,
   input wire [15:0] phaseCFrequency,
   input wire [15:0] phaseACurrentRms,
   input wire [15:0] phaseBCurrentRms,
   input wire [15:0] phaseCCurrentRms,
   input wire [15:0] firstVoltageRms,
   input wire [15:0] secondVoltageRms,
   input wire [15:0] thirdVoltageRms,
   input wire [15:0] fourthVoltageRms,
   input wire [15:0] phaseNeutralARms,
   input wire [15:0] phaseNeutralBRms,
   input wire [15:0] phaseNeutralCRms,
   input wire [15:0] firstAngle,
   input wire [15:0] secondAngle,
   input wire [15:0] thirdAngle,
   input wire [1:0] eventStoreSelect,
   output reg memoryInUse_ff,
   output reg unidirectionalFallback_ff,
   output reg freqFromCurrent_ff,
   output reg [15:0] samplingFrequency_ff,
   output reg [15:0] voltageAmplitude_ff,
   output reg [15:0] firstAngleOut_ff,
   output reg [15:0] secondAngleOut_ff,
   output reg [15:0] thirdAngleOut_ff,
   output reg eventValid_ff,
   output reg [3:0] eventCode_ff
);
   // ****************************************************************
   // Program cycle and hold time bases
   // ****************************************************************
   wire cycleTick;
   wire holdStep;

   // Program cycle follows the RMS refresh period
   pulse_divider #(.LIMIT(CYCLE_TICKS)) u_cycle_div
   (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .run(1'b1),
      .tick_ff(cycleTick)
   );

   // Hold limit counts in 10 ms steps while engaged
   pulse_divider #(.LIMIT(HOLD_TICKS)) u_hold_div
   (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .run(memoryInUse_ff),
      .tick_ff(holdStep)
   );

   // ****************************************************************
   // Voltage and current conditions
   // ****************************************************************
   reg [15:0] engageLevel;
   reg [15:0] holdSteps;
   reg voltageLow;
   reg currentHigh;

   // Clamp settings into their documented ranges
   always @*
   begin
      engageLevel = memoryEngageThreshold;
      if (engageLevel < `ENGAGE_MIN_V)
         engageLevel = `ENGAGE_MIN_V;
      if (engageLevel > `ENGAGE_MAX_V)
         engageLevel = `ENGAGE_MAX_V;
      holdSteps = memoryHoldLimit;
      if (holdSteps < `HOLD_MIN_STEPS)
         holdSteps = `HOLD_MIN_STEPS;
      if (holdSteps > `HOLD_MAX_STEPS)
         holdSteps = `HOLD_MAX_STEPS;
   end

   // Choose the used channels per voltage mode
   always @*
   begin
      case (voltageMode)
         `MODE_TWO_LINE_LINE:
            voltageLow = (firstVoltageRms < engageLevel) &&
               (secondVoltageRms < engageLevel);
         `MODE_TWO_LINE_PLUS_RESIDUAL:
            voltageLow = (phaseNeutralARms < engageLevel) &&
               (phaseNeutralBRms < engageLevel) &&
               (phaseNeutralCRms < engageLevel);
         default:
            voltageLow = (firstVoltageRms < engageLevel) &&
               (secondVoltageRms < engageLevel) &&
               (thirdVoltageRms < engageLevel);
      endcase
      currentHigh = (phaseACurrentRms > currentQualifyThreshold) ||
         (phaseBCurrentRms > currentQualifyThreshold) ||
         (phaseCCurrentRms > currentQualifyThreshold);
   end

   // ****************************************************************
   // Program cycle sampling and engage control
   // ****************************************************************
   reg block_ff;
   reg vlow_ff;
   reg ihigh_ff;
   reg enable_ff;
   reg [15:0] holdCount_ff;
   reg [15:0] angleA_ff;
   reg [15:0] angleB_ff;
   reg [15:0] angleC_ff;
   reg expired_ff;
   wire engageCond;
   wire holdDone;

   assign engageCond = enable_ff && !block_ff && vlow_ff &&
      (!currentQualifyEnable || ihigh_ff);
   assign holdDone = memoryInUse_ff && holdStep && (holdCount_ff + 16'h0001 >= holdSteps);

   // Sample inputs at each program cycle start, run the engage state
   always @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         block_ff <= 1'b0;
         vlow_ff <= 1'b0;
         ihigh_ff <= 1'b0;
         enable_ff <= 1'b0;
         memoryInUse_ff <= 1'b0;
         expired_ff <= 1'b0;
         holdCount_ff <= 16'h0000;
         angleA_ff <= 16'h0000;
         angleB_ff <= 16'h0000;
         angleC_ff <= 16'h0000;
      end
      else
      begin
         if (cycleTick)
         begin
            block_ff <= memoryBlock;
            vlow_ff <= voltageLow;
            ihigh_ff <= currentHigh;
            enable_ff <= memoryEnable;
         end
         // Track pre-fault angles only while not engaged
         if (!memoryInUse_ff && !vlow_ff)
         begin
            angleA_ff <= firstAngle;
            angleB_ff <= secondAngle;
            angleC_ff <= thirdAngle;
         end
         if (memoryInUse_ff)
         begin
            if (!enable_ff || block_ff || holdDone)
            begin
               memoryInUse_ff <= 1'b0;
               expired_ff <= holdDone;
            end
            else if (holdStep)
               holdCount_ff <= holdCount_ff + 16'h0001;
         end
         else
         begin
            holdCount_ff <= 16'h0000;
            if (!vlow_ff)
               expired_ff <= 1'b0;
            else if (engageCond && !expired_ff)
               memoryInUse_ff <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Outputs toward the protection stages
   // ****************************************************************
   always @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         unidirectionalFallback_ff <= 1'b0;
         freqFromCurrent_ff <= 1'b0;
         samplingFrequency_ff <= 16'h0000;
         voltageAmplitude_ff <= 16'h0000;
         firstAngleOut_ff <= 16'h0000;
         secondAngleOut_ff <= 16'h0000;
         thirdAngleOut_ff <= 16'h0000;
      end
      else
      begin
         unidirectionalFallback_ff <= expired_ff;
         freqFromCurrent_ff <= currentBasedFreqFollow && fixedSamplingMode && vlow_ff;
         if (currentBasedFreqFollow && fixedSamplingMode && vlow_ff)
            samplingFrequency_ff <= phaseCFrequency;
         else
            samplingFrequency_ff <= fixedFrequency;
         if (memoryInUse_ff)
         begin
            voltageAmplitude_ff <= engageLevel;
            firstAngleOut_ff <= angleA_ff;
            secondAngleOut_ff <= angleB_ff;
            thirdAngleOut_ff <= angleC_ff;
         end
         else
         begin
            voltageAmplitude_ff <= firstVoltageRms;
            firstAngleOut_ff <= firstAngle;
            secondAngleOut_ff <= secondAngle;
            thirdAngleOut_ff <= thirdAngle;
         end
      end
   end

   // ****************************************************************
   // Events
   // ****************************************************************
   reg [4:0] prev_ff;
   wire [4:0] curState;
   wire [`EV_COUNT-1:0] evStrobe;
   wire [`EV_COUNT-1:0] evStoreMask;
   wire evValid;
   wire [3:0] evCode;

   assign curState = {block_ff, memoryInUse_ff, freqFromCurrent_ff, ihigh_ff, vlow_ff};

   // Previous state for edge detection
   always @(posedge sys_clk)
   begin
      if (!resetn)
         prev_ff <= 5'h00;
      else
         prev_ff <= curState;
   end

   // One ON/OFF strobe pair per condition, bit 0 of select keeps ON, bit 1 keeps OFF
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1)
      begin : g_ev
         if (g == 0)
         begin : g_en
            reg enPrev_ff;
            always @(posedge sys_clk)
            begin
               if (!resetn)
                  enPrev_ff <= 1'b0;
               else
                  enPrev_ff <= enable_ff;
            end
            assign evStrobe[0] = enable_ff && !enPrev_ff;
            assign evStrobe[1] = !enable_ff && enPrev_ff;
         end
         else
         begin : g_cond
            assign evStrobe[2*g] = curState[g-1] && !prev_ff[g-1];
            assign evStrobe[2*g+1] = !curState[g-1] && prev_ff[g-1];
         end
         assign evStoreMask[2*g] = eventStoreSelect[0];
         assign evStoreMask[2*g+1] = eventStoreSelect[1];
      end
   endgenerate

   event_encoder u_events
   (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .evStrobe(evStrobe),
      .evStoreMask(evStoreMask),
      .evValid_ff(evValid),
      .evCode_ff(evCode)
   );

   // Register event outputs at the top boundary
   always @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         eventValid_ff <= 1'b0;
         eventCode_ff <= 4'h0;
      end
      else
      begin
         eventValid_ff <= evValid;
         eventCode_ff <= evCode;
      end
   end
endmodule

//--- dv/voltage_angle_memory_assertions.sv
// Checker for the voltage angle memory: engage gating, held outputs, fallback, events.
// Assumes it is bound to the top module; the engage threshold and hold limit stay in range.
`timescale 1ns/1ns
`include "voltage_memory_map.vh"
module voltage_angle_memory_assertions
#(
   parameter [31:0] HOLD_TICKS = `HOLD_STEP_CYCLES
)
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic memoryEnable,
   input wire logic memoryBlock,
   input wire logic [15:0] memoryEngageThreshold,
   input wire logic [15:0] memoryHoldLimit,
   input wire logic [1:0] eventStoreSelect,
   input wire logic memoryInUse_ff,
   input wire logic unidirectionalFallback_ff,
   input wire logic [15:0] voltageAmplitude_ff,
   input wire logic [15:0] firstAngleOut_ff,
   input wire logic eventValid_ff,
   input wire logic [3:0] eventCode_ff
);
   logic [31:0] useCnt_ff;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // ********
   // Engaged time counter
   // ********
   always @(posedge sys_clk)
      useCnt_ff <= (!resetn || !memoryInUse_ff) ? 32'h0 : useCnt_ff + 32'h1;
   // Rise of in-use, then one more engaged cycle
   sequence s_engage;
      $rose(memoryInUse_ff) ##1 memoryInUse_ff;
   endsequence
   // ********
   // Properties
   // ********
   chk_enable_gate: assert property ($rose(memoryInUse_ff) |-> $past(memoryEnable))
      else $error("in-use rose while disabled");
   chk_block_gate: assert property ($rose(memoryInUse_ff) |-> !$past(memoryBlock))
      else $error("in-use rose while blocked");
   chk_amp_hold: assert property (s_engage |-> voltageAmplitude_ff == memoryEngageThreshold)
      else $error("amplitude not threshold");
   chk_angle_frozen: assert property (memoryInUse_ff && $past(memoryInUse_ff, 2)
      |-> $stable(firstAngleOut_ff))
      else $error("angle moved while engaged");
   chk_fallback_order: assert property ($rose(unidirectionalFallback_ff)
      |-> !$past(memoryInUse_ff) && $past(memoryInUse_ff, 2))
      else $error("fallback not after expiry");
   chk_fallback_excl: assert property (unidirectionalFallback_ff |-> !memoryInUse_ff)
      else $error("fallback while engaged");
   chk_event_code: assert property (eventValid_ff |-> eventCode_ff <= 4'hB)
      else $error("bad event code");
   chk_event_store: assert property (eventValid_ff
      |-> (eventCode_ff[0] ? eventStoreSelect[1] : eventStoreSelect[0]))
      else $error("event sent though not selected");
   chk_inuse_event: assert property (s_engage ##0 eventStoreSelect[0]
      |-> ##[0:20] (eventValid_ff && eventCode_ff == 4'h8))
      else $error("no in-use event");
   chk_hold_limit: assert property (64'(useCnt_ff)
      <= 64'(memoryHoldLimit) * 64'(HOLD_TICKS) + 64'h4)
      else $error("engaged past hold limit");
endmodule
bind voltage_angle_memory voltage_angle_memory_assertions #(.HOLD_TICKS(HOLD_TICKS))
   chkU (.sys_clk, .resetn,
   .memoryEnable, .memoryBlock, .memoryEngageThreshold, .memoryHoldLimit, .eventStoreSelect,
   .memoryInUse_ff, .unidirectionalFallback_ff, .voltageAmplitude_ff, .firstAngleOut_ff,
   .eventValid_ff, .eventCode_ff);

//--- dv/rms_front_end.sv
// Measurement front end model: RMS values, angles and frequencies for the block.
// Assumes the bench sets targets; they appear on the edge after they are set.
`timescale 1ns/1ns
module rms_front_end
(
   input wire logic sys_clk,
   input wire logic [15:0] target [15],
   output logic [15:0] measured [15]
);
   // Present commanded measurements
   always @(posedge sys_clk)
      measured <= target;
endmodule

//--- dv/voltage_angle_memory_tb.sv
// Bench for the voltage angle memory: one step per program cycle tick, model compared.
// Assumes shortened tick and hold step lengths passed as parameters; hold limit of 2 steps.
`timescale 1ns/1ns
module voltage_angle_memory_tb;
   localparam integer TICK = 200;
   localparam [15:0] THR = 16'h03E8;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic en = 1'b0;
   logic blk = 1'b0;
   logic cq = 1'b0;
   logic [1:0] md = 2'h0;
   logic [1:0] sel = 2'h3;
   logic cf = 1'b0;
   logic fx = 1'b0;
   logic [15:0] sv [15];
   logic [15:0] mv [15];
   logic inUse, fb, ffc, evV;
   logic [15:0] sf, amp, a1, a2, a3;
   logic [3:0] evC;
   logic [15:0] evTally [12];
   integer expTally [12];
   integer nFail = 0;
   integer comparisons = 0;
   integer held = 0;
   logic eng = 1'b0;
   logic expd = 1'b0;
   logic prevLow = 1'b0;
   logic prevEn = 1'b0;
   logic prevHi = 1'b0;
   logic prevBlk = 1'b0;
   logic prevFfc = 1'b0;
   logic prevEng = 1'b0;
   logic [15:0] lat = 16'h0000;
   logic [15:0] lat2 = 16'h0000;
   logic [15:0] lat3 = 16'h0000;
   // ********
   // Clock, front end and design
   // ********
   initial forever #2 sys_clk = ~sys_clk;
   initial foreach (sv[i]) sv[i] = 16'h0800;
   rms_front_end feU (.sys_clk(sys_clk), .target(sv), .measured(mv));
   voltage_angle_memory #(.CYCLE_TICKS(TICK), .HOLD_TICKS(2 * TICK)) dut_u (.sys_clk(sys_clk),
      .resetn(resetn), .memoryEnable(en),
      .currentQualifyEnable(cq), .currentBasedFreqFollow(cf), .fixedSamplingMode(fx),
      .voltageMode(md), .memoryEngageThreshold(THR), .currentQualifyThreshold(16'h01F4),
      .memoryHoldLimit(16'h0002), .memoryBlock(blk), .fixedFrequency(mv[13]),
      .phaseCFrequency(mv[14]), .phaseACurrentRms(mv[0]), .phaseBCurrentRms(mv[1]),
      .phaseCCurrentRms(mv[2]), .firstVoltageRms(mv[3]), .secondVoltageRms(mv[4]),
      .thirdVoltageRms(mv[5]), .fourthVoltageRms(mv[6]), .phaseNeutralARms(mv[7]),
      .phaseNeutralBRms(mv[8]), .phaseNeutralCRms(mv[9]), .firstAngle(mv[10]),
      .secondAngle(mv[11]), .thirdAngle(mv[12]), .eventStoreSelect(sel),
      .memoryInUse_ff(inUse), .unidirectionalFallback_ff(fb), .freqFromCurrent_ff(ffc),
      .samplingFrequency_ff(sf), .voltageAmplitude_ff(amp), .firstAngleOut_ff(a1),
      .secondAngleOut_ff(a2), .thirdAngleOut_ff(a3), .eventValid_ff(evV), .eventCode_ff(evC));
   // Count each event code leaving the design
   always @(posedge sys_clk)
      if (!resetn)
         foreach (evTally[i])
            evTally[i] <= 16'h0000;
      else if (evV)
         evTally[evC] <= evTally[evC] + 16'h0001;
   // ********
   // Tasks
   // ********
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         nFail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task printVerdict;
      if (nFail == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Apply one step's inputs, let the tick pass, then compare with the model
   // Expected event for one condition change, kept only if its direction is selected
   task automatic ev(input logic was, input logic now, input integer code);
      if (was != now && (now ? sel[0] : sel[1]))
         expTally[now ? code : code + 1]++;
   endtask
   task automatic step(input logic [1:0] m, input logic e, b, c, lo, hi);
      logic low;
      logic mid;
      md = m;
      en = e;
      blk = b;
      cq = c;
      sel = lo ? 2'h3 : 2'($urandom);
      cf = 1'($urandom);
      fx = 1'($urandom);
      mid = cf && fx && prevLow;
      for (int i = 0; i < 15; i++)
         if (i < 10 || i > 12 || !(lo && !prevLow))
            sv[i] = 16'h07D0 + 16'($urandom % 20000);
      for (int i = 0; i < 3; i++)
         sv[i] = hi ? 16'h01F5 + 16'($urandom % 999) : 16'($urandom % 501);
      for (int i = 3; i < 10; i++)
         if (lo && ((m == 2'h3) ? i > 6 : (i < 5 || (i == 5 && m != 2'h2))))
            sv[i] = 16'($urandom % 1000);
      repeat (120) @(posedge sys_clk);
      #1;
      low = (m == 2'h3) ? (sv[7] < THR && sv[8] < THR && sv[9] < THR)
         : (sv[3] < THR && sv[4] < THR && (m == 2'h2 || sv[5] < THR));
      if (!e || b)
         eng = 1'b0;
      else if (eng)
      begin
         held++;
         if (held >= 4)
         begin
            eng = 1'b0;
            expd = 1'b1;
         end
      end
      else if (!expd && low && (!c || hi))
      begin
         eng = 1'b1;
         held = 0;
      end
      if (!low)
      begin
         expd = 1'b0;
         lat = sv[10];
         lat2 = sv[11];
         lat3 = sv[12];
      end
      ev(prevEn, e, 0);
      ev(prevLow, low, 2);
      ev(prevHi, hi, 4);
      ev(prevFfc, mid, 6);
      ev(mid, cf && fx && low, 6);
      ev(prevEng, eng, 8);
      ev(prevBlk, b, 10);
      prevLow = low;
      prevEn = e;
      prevHi = hi;
      prevBlk = b;
      prevFfc = cf && fx && low;
      prevEng = eng;
      check(inUse, eng);
      check(fb, expd);
      check(amp, eng ? THR : sv[3]);
      check(a1, eng ? lat : sv[10]);
      check(a2, eng ? lat2 : sv[11]);
      check(a3, eng ? lat3 : sv[12]);
      check(ffc, cf && fx && low);
      check(sf, (cf && fx && low) ? sv[14] : sv[13]);
      for (int i = 0; i < 12; i++)
         check(evTally[i], 16'(expTally[i]));
      repeat (TICK - 120) @(posedge sys_clk);
      #1;
   endtask
   // ********
   // Main sequence
   // ********
   initial
   begin
      void'($urandom(72));
      foreach (expTally[i])
         expTally[i] = 0;
      repeat (5) @(posedge sys_clk);
      #1;
      resetn = 1'b1;
      repeat (TICK - 100) @(posedge sys_clk);
      #1;
      step(2'h0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      step(2'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
      step(2'h0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      step(2'h1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
      for (int k = 0; k < 5; k++)
         step(2'h2, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
      step(2'h2, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
      step(2'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
      step(2'h3, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
      step(2'h3, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
      printVerdict();
   end
endmodule
